// ### rtl/sfc_cmd.sv
// Signed frequency command interpreter with fault record store
// Summary of operation
// - Sign select setting 0 or 1, default 0
// - Unsigned word limited 59000, or 65535 scaled
// - Signed word read as two's complement
// - Negative frequency inverts requested rotation direction
// - Signed mode rejects link non-volatile set; code write sets RAM only; error H01
// - Both requests with extended setting: RAM only
// - Reset clears sign positive, frequency zero
// - Instruction code frequency writes keep stored sign
// - Refresh interval between 1.1 ms and 141 ms; only the upper limit is watched
// - Error reset acts only during active fault
// - History clear erases all ten fault records
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd #(
   parameter int REFRESH_MAX_CYC = sfc_pkg::SFC_REFRESH_MAX_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // Link-side inputs, refreshed from the master (pin domain)
   input wire logic [15:0] freq_command_word,
   input wire logic freq_set_ram_request,
   input wire logic freq_set_ram_nv_request,
   input wire logic fwd_cmd,
   input wire logic rev_cmd,
   input wire logic error_reset_cmd,
   input wire logic hist_clear_cmd,
   input wire logic refresh_strobe,
   // Instruction code path
   input wire logic code_valid,
   input wire logic [7:0] code_value,
   input wire logic [15:0] code_data,
   // Drive fault reporting
   input wire logic fault_event,
   input wire logic [7:0] fault_code,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Results
   output logic [15:0] set_freq,
   output logic set_sign_neg,
   output logic run_fwd,
   output logic run_rev,
   output logic ram_done,
   output logic nv_done,
   output logic nv_write,
   output logic [7:0] error_code,
   output logic fault_active,
   output logic refresh_timeout,
   output logic irq
);
   import sfc_pkg::*;

   logic [2:0] ctrl_q;
   logic [4:0] irq_stat_q;
   logic [4:0] irq_mask_q;
   logic [15:0] freq_q;
   logic sign_q;
   logic fault_q;
   logic [7:0] err_q;
   logic ram_done_q;
   logic nv_done_q;
   logic nv_write_q;
   logic run_fwd_q;
   logic run_rev_q;
   logic [31:0] rdata_q;
   logic [31:0] wd_cnt_q;
   logic tmo_q;
   logic [7:0] hist_q [SFC_FAULT_RECORDS];
   logic [3:0] hist_cnt_q;

   // Three-stage synchronisers for all pin-domain inputs
   localparam int NSYNC = 23;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q;
   assign pin_raw = {freq_command_word, freq_set_ram_request,
                     freq_set_ram_nv_request, fwd_cmd, rev_cmd,
                     error_reset_cmd, hist_clear_cmd, refresh_strobe};

   // Stage registers; a change is taken once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               pin_q[gi] <= 1'b0;
            end else if (clk_en) begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) begin
                  pin_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

   logic [15:0] cmd_word;
   logic req_ram, req_nv, fwd_in, rev_in, err_rst_in, hclr_in, refresh_in;
   assign {cmd_word, req_ram, req_nv, fwd_in, rev_in,
           err_rst_in, hclr_in, refresh_in} = pin_q;

   // Rising edges of request bits
   logic req_ram_d1_q, req_nv_d1_q, err_rst_d1_q, hclr_d1_q, refresh_d1_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         req_ram_d1_q <= 1'b0;
         req_nv_d1_q <= 1'b0;
         err_rst_d1_q <= 1'b0;
         hclr_d1_q <= 1'b0;
         refresh_d1_q <= 1'b0;
      end else if (clk_en) begin
         req_ram_d1_q <= req_ram;
         req_nv_d1_q <= req_nv;
         err_rst_d1_q <= err_rst_in;
         hclr_d1_q <= hclr_in;
         refresh_d1_q <= refresh_in;
      end
   end

   logic ram_rise, nv_rise, err_rst_rise, hclr_rise, refresh_rise;
   assign ram_rise = req_ram & ~req_ram_d1_q;
   assign nv_rise = req_nv & ~req_nv_d1_q;
   assign err_rst_rise = err_rst_in & ~err_rst_d1_q;
   assign hclr_rise = hclr_in & ~hclr_d1_q;
   assign refresh_rise = refresh_in & ~refresh_d1_q;

   logic sign_mode, ext_mode, scaled_mode;
   assign sign_mode = ctrl_q[SFC_CTRL_SIGN_BIT];
   assign ext_mode = ctrl_q[SFC_CTRL_EXT_BIT];
   assign scaled_mode = ctrl_q[SFC_CTRL_SCALE_BIT];

   // Request arbitration and acceptance checks
   logic do_ram, do_nv, range_ok, nv_reject, code_ram, code_nv;
   always_comb begin
      // With the extended setting both may rise together; RAM wins
      do_ram = ram_rise;
      do_nv = nv_rise & ~(ext_mode & ram_rise);
      // Without the extended setting only one runs; RAM first too
      if (!ext_mode && ram_rise) begin
         do_nv = 1'b0;
      end
      // Unsigned limit unless scaled or signed
      range_ok = sign_mode | scaled_mode |
                 (cmd_word <= SFC_FREQ_MAX_UNSCALED);
      nv_reject = do_nv & sign_mode;
      code_ram = code_valid & (code_value == SFC_CODE_WR_RAM);
      code_nv = code_valid & (code_value == SFC_CODE_WR_NV);
   end

   // Frequency word and sign store
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         freq_q <= SFC_FREQ_RESET;
         sign_q <= 1'b0;
         nv_write_q <= 1'b0;
      end else if (clk_en) begin
         nv_write_q <= 1'b0;
         if ((do_ram || (do_nv && !nv_reject)) && range_ok) begin
            if (sign_mode) begin
               // Two's complement: keep magnitude, record sign
               sign_q <= cmd_word[15];
               freq_q <= cmd_word[15] ? 16'(~cmd_word + 16'h0001)
                                      : cmd_word;
            end else begin
               sign_q <= 1'b0;
               freq_q <= cmd_word;
            end
            nv_write_q <= do_nv;
         end else if ((code_ram || code_nv) &&
                      (sign_mode || scaled_mode ||
                       code_data <= SFC_FREQ_MAX_UNSCALED)) begin
            freq_q <= code_data;  // sign untouched
            nv_write_q <= code_nv & ~sign_mode;
         end
      end
   end

   // Completion pulses and error code
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ram_done_q <= 1'b0;
         nv_done_q <= 1'b0;
         err_q <= SFC_ERR_NONE;
      end else if (clk_en) begin
         ram_done_q <= do_ram & range_ok;
         nv_done_q <= do_nv & ~nv_reject & range_ok;
         if (nv_reject || (code_nv && sign_mode)) begin
            err_q <= SFC_ERR_WRITE_MODE;
         end else if ((do_ram || do_nv) && !range_ok) begin
            err_q <= SFC_ERR_RANGE;
         end else if (do_ram || do_nv || code_valid) begin
            err_q <= SFC_ERR_NONE;
         end
      end
   end

   // Actual run direction from start command and sign
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_fwd_q <= 1'b0;
         run_rev_q <= 1'b0;
      end else if (clk_en) begin
         if (fwd_in == rev_in) begin
            run_fwd_q <= 1'b0;
            run_rev_q <= 1'b0;
         end else begin
            run_fwd_q <= fwd_in ^ (sign_mode & sign_q);
            run_rev_q <= rev_in ^ (sign_mode & sign_q);
         end
      end
   end

   // Fault state; the network reset only clears an active fault
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fault_q <= 1'b0;
      end else if (clk_en) begin
         if (fault_event) begin
            fault_q <= 1'b1;
         end else if (err_rst_rise && fault_q) begin
            fault_q <= 1'b0;
         end
      end
   end

   // Fault record store, newest in slot 0; cleared on command
   generate
      for (gi = 0; gi < SFC_FAULT_RECORDS; gi++) begin : g_hist
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               hist_q[gi] <= 8'h00;
            end else if (clk_en) begin
               if (hclr_rise) begin
                  hist_q[gi] <= 8'h00;
               end else if (fault_event && !fault_q) begin
                  hist_q[gi] <= (gi == 0) ? fault_code
                                          : hist_q[(gi == 0) ? 0 : gi - 1];
               end
            end
         end
      end
   endgenerate

   // Count of stored records
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hist_cnt_q <= 4'h0;
      end else if (clk_en) begin
         if (hclr_rise) begin
            hist_cnt_q <= 4'h0;
         end else if (fault_event && !fault_q &&
                      hist_cnt_q != 4'(SFC_FAULT_RECORDS)) begin
            hist_cnt_q <= hist_cnt_q + 4'h1;
         end
      end
   end

   // Refresh watchdog: flags a gap longer than the longest interval
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt_q <= 32'h0;
         tmo_q <= 1'b0;
      end else if (clk_en) begin
         if (refresh_rise) begin
            wd_cnt_q <= 32'h0;
            tmo_q <= 1'b0;
         end else if (wd_cnt_q >= 32'(REFRESH_MAX_CYC)) begin
            tmo_q <= 1'b1;
         end else begin
            wd_cnt_q <= wd_cnt_q + 32'h1;
         end
      end
   end

   // Interrupt events; set wins over write-one-to-clear
   logic [4:0] irq_ev;
   assign irq_ev = {hclr_rise, err_rst_rise & fault_q,
                    nv_reject | ((do_ram | do_nv) & ~range_ok),
                    do_nv & ~nv_reject & range_ok, do_ram & range_ok};

   // Control, status and mask registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= SFC_CTRL_RESET;
         irq_stat_q <= SFC_IRQ_RESET;
         irq_mask_q <= SFC_IRQ_RESET;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == SFC_ADDR_CTRL) begin
            ctrl_q <= reg_wdata[2:0];
         end
         if (reg_wr && reg_addr == SFC_ADDR_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[4:0];
         end
         if (reg_wr && reg_addr == SFC_ADDR_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata[4:0]) | irq_ev;
         end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
         end
      end
   end

   // Read data, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h0;
      end else if (clk_en) begin
         rdata_q <= 32'h0;
         if (reg_rd) begin
            if (reg_addr == SFC_ADDR_CTRL) begin
               rdata_q <= {29'h0, ctrl_q};
            end else if (reg_addr == SFC_ADDR_STATUS) begin
               rdata_q <= {16'h0, err_q, hist_cnt_q, tmo_q, fault_q,
                           sign_q, run_fwd_q};
            end else if (reg_addr == SFC_ADDR_IRQ_STAT) begin
               rdata_q <= {27'h0, irq_stat_q};
            end else if (reg_addr == SFC_ADDR_IRQ_MASK) begin
               rdata_q <= {27'h0, irq_mask_q};
            end else if (reg_addr == SFC_ADDR_FREQ) begin
               rdata_q <= {15'h0, sign_q, freq_q};
            end else if (reg_addr >= SFC_ADDR_FAULT_BASE && reg_addr <
                         SFC_ADDR_FAULT_BASE + 4'(SFC_FAULT_RECORDS)) begin
               rdata_q <= {24'h0, hist_q[4'(reg_addr - SFC_ADDR_FAULT_BASE)]};
            end
         end
      end
   end

   // Level interrupt from a flip-flop
   logic irq_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(irq_stat_q & irq_mask_q);  // Mask bit high enables
      end
   end

   assign reg_rdata = rdata_q;
   assign set_freq = freq_q;
   assign set_sign_neg = sign_q;
   assign run_fwd = run_fwd_q;
   assign run_rev = run_rev_q;
   assign ram_done = ram_done_q;
   assign nv_done = nv_done_q;
   assign nv_write = nv_write_q;
   assign error_code = err_q;
   assign fault_active = fault_q;
   assign refresh_timeout = tmo_q;
   assign irq = irq_q;
endmodule : sfc_cmd
`default_nettype wire

// ### rtl/sfc_pkg.sv
// Package for the signed frequency command interpreter
package sfc_pkg;
   localparam logic [15:0] SFC_FREQ_MAX_UNSCALED = 16'he678; // 59000 = 590.00 Hz
   localparam logic [15:0] SFC_FREQ_RESET = 16'h0000;
   localparam logic [7:0] SFC_ERR_NONE = 8'h00;
   localparam logic [7:0] SFC_ERR_WRITE_MODE = 8'h01;
   localparam logic [7:0] SFC_ERR_RANGE = 8'h03;
   localparam logic [7:0] SFC_CODE_WR_RAM = 8'hed;
   localparam logic [7:0] SFC_CODE_WR_NV = 8'hee;
   localparam int SFC_FAULT_RECORDS = 10;
   localparam logic [3:0] SFC_ADDR_CTRL = 4'h0;
   localparam logic [3:0] SFC_ADDR_STATUS = 4'h1;
   localparam logic [3:0] SFC_ADDR_IRQ_STAT = 4'h2;
   localparam logic [3:0] SFC_ADDR_IRQ_MASK = 4'h3;
   localparam logic [3:0] SFC_ADDR_FREQ = 4'h4;
   localparam logic [3:0] SFC_ADDR_FAULT_BASE = 4'h5;
   localparam int SFC_CTRL_SIGN_BIT = 0;
   localparam int SFC_CTRL_EXT_BIT = 1;
   localparam int SFC_CTRL_SCALE_BIT = 2;
   localparam int SFC_IRQ_RAM_DONE = 0;
   localparam int SFC_IRQ_NV_DONE = 1;
   localparam int SFC_IRQ_ERROR = 2;
   localparam int SFC_IRQ_FAULT_RESET = 3;
   localparam int SFC_IRQ_HIST_CLEAR = 4;
   localparam logic [4:0] SFC_IRQ_RESET = 5'h00;
   localparam logic [2:0] SFC_CTRL_RESET = 3'h0;
   // Cyclic refresh interval bounds, microseconds
   localparam int SFC_REFRESH_MIN_US = 1100;
   localparam int SFC_REFRESH_MAX_US = 141000;
   localparam int SFC_CLK_MHZ = 50;
   localparam int SFC_REFRESH_MIN_CYC = SFC_REFRESH_MIN_US * SFC_CLK_MHZ;
   localparam int SFC_REFRESH_MAX_CYC = SFC_REFRESH_MAX_US * SFC_CLK_MHZ;
endpackage : sfc_pkg

// ### testbench/sfc_cmd_monitor.sv
// Port-level assertion checker for the frequency command interpreter
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_monitor
   import sfc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic reg_rd,
   input wire logic code_valid,
   input wire logic [31:0] reg_rdata,
   input wire logic [15:0] set_freq,
   input wire logic set_sign_neg,
   input wire logic run_fwd,
   input wire logic run_rev,
   input wire logic ram_done,
   input wire logic nv_done,
   input wire logic nv_write
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Completion strobes last exactly one cycle
   a_ram_done_pulse: assert property (ram_done |=> !ram_done)
      else $error("ram done held too long");
   a_nv_done_pulse: assert property (nv_done |=> !nv_done)
      else $error("nv done held too long");
   a_nv_write_pulse: assert property (nv_write |=> !nv_write)
      else $error("nv write held too long");
   // Read data only in the cycle after a read strobe
   a_rdata_idle_zero: assert property (
      clk_en && !reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   // Direction outputs never both active
   a_run_dir_excl: assert property (!(run_fwd && run_rev))
      else $error("both directions active");
   // Reset leaves a positive sign and zero frequency
   a_reset_clears: assert property (
      $rose(rst_n) |-> set_freq == SFC_FREQ_RESET && !set_sign_neg)
      else $error("frequency not cleared by reset");
   // Frequency moves only with an accepted request or a code write
   a_freq_needs_req: assert property (
      $changed(set_freq) |-> ram_done || nv_done || $past(code_valid))
      else $error("frequency changed without request");
   // A code write keeps the stored sign
   a_code_keeps_sign: assert property (
      $past(code_valid) && !ram_done && !nv_done |-> $stable(set_sign_neg))
      else $error("code write changed sign");
   c_ram_set: cover property (ram_done);
   c_nv_store: cover property (nv_write);
   c_reverse: cover property (run_rev);
endmodule : sfc_cmd_monitor
bind sfc_cmd sfc_cmd_monitor sfc_cmd_monitor_inst (.clock, .rst_n,
   .clk_en, .reg_rd, .code_valid, .reg_rdata, .set_freq, .set_sign_neg,
   .run_fwd, .run_rev, .ram_done, .nv_done, .nv_write);
`default_nettype wire

// ### testbench/sfc_master_model.sv
// Behavioural master station on the link side of the interpreter
`timescale 1ns/1ps
`default_nettype none
module sfc_master_model #(
   parameter int REFRESH_CYC = 40
) (
   input wire logic clock,
   input wire logic refresh_run,
   output logic [15:0] freq_command_word,
   output logic freq_set_ram_request,
   output logic freq_set_ram_nv_request,
   output logic error_reset_cmd,
   output logic hist_clear_cmd,
   output logic refresh_strobe
);
   int cnt = 0;
   initial begin
      freq_command_word = 16'h0000;
      freq_set_ram_request = 1'b0;
      freq_set_ram_nv_request = 1'b0;
      error_reset_cmd = 1'b0;
      hist_clear_cmd = 1'b0;
      refresh_strobe = 1'b0;
   end
   // Cyclic refresh; frames stop while refresh_run is low
   always @(posedge clock) begin
      if (refresh_run) begin
         cnt <= (cnt == REFRESH_CYC / 2 - 1) ? 0 : cnt + 1;
         if (cnt == REFRESH_CYC / 2 - 1) begin
            refresh_strobe <= !refresh_strobe;
         end
      end
   end
   // Request levels held long enough to cross the input synchroniser
   task automatic request(input logic [15:0] v, input logic r, input logic n);
      @(posedge clock);
      freq_command_word <= v;
      freq_set_ram_request <= r;
      freq_set_ram_nv_request <= n;
      repeat (8) @(posedge clock);
      freq_set_ram_request <= 1'b0;
      freq_set_ram_nv_request <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : request
   // Error reset or history clear command
   task automatic pulse_cmd(input logic hist);
      @(posedge clock);
      if (hist) hist_clear_cmd <= 1'b1;
      else error_reset_cmd <= 1'b1;
      repeat (8) @(posedge clock);
      hist_clear_cmd <= 1'b0;
      error_reset_cmd <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : pulse_cmd
endmodule : sfc_master_model
`default_nettype wire

// ### testbench/signed_frequency_command_bench.sv
// Self-checking bench for the frequency command interpreter
`timescale 1ns/1ps
`default_nettype none
module signed_frequency_command_bench;
   import sfc_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic refresh_run = 1'b1;
   logic fwd_cmd = 1'b0;
   logic rev_cmd = 1'b0;
   logic code_valid = 1'b0;
   logic [7:0] code_value = 8'h00;
   logic [15:0] code_data = 16'h0000;
   logic fault_event = 1'b0;
   logic [7:0] fault_code = 8'h00;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, d;
   logic [15:0] freq_command_word, set_freq, w;
   logic freq_set_ram_request, freq_set_ram_nv_request, refresh_strobe;
   logic error_reset_cmd, hist_clear_cmd, set_sign_neg, run_fwd, run_rev;
   logic ram_done, nv_done, nv_write, fault_active, refresh_timeout, irq;
   logic [7:0] error_code;
   int ram_cnt = 0;
   int nv_cnt = 0;
   int nvw_cnt = 0;
   int ram_base = 0;
   int nv_base = 0;
   int nvw_base = 0;
   int err_count = 0;
   int compares = 0;
   always #10 clock = ~clock;
   sfc_cmd #(.REFRESH_MAX_CYC(50)) sfc_cmd_inst (.clock, .rst_n, .clk_en,
      .freq_command_word, .freq_set_ram_request, .freq_set_ram_nv_request,
      .fwd_cmd, .rev_cmd, .error_reset_cmd, .hist_clear_cmd, .refresh_strobe,
      .code_valid, .code_value, .code_data, .fault_event, .fault_code,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .set_freq,
      .set_sign_neg, .run_fwd, .run_rev, .ram_done, .nv_done, .nv_write,
      .error_code, .fault_active, .refresh_timeout, .irq);
   sfc_master_model #(.REFRESH_CYC(40)) sfc_master_model_inst (.clock,
      .refresh_run, .freq_command_word, .freq_set_ram_request,
      .freq_set_ram_nv_request, .error_reset_cmd, .hist_clear_cmd,
      .refresh_strobe);
   // Running count of completion and store pulses
   always @(posedge clock) begin
      if (ram_done) ram_cnt <= ram_cnt + 1;
      if (nv_done) nv_cnt <= nv_cnt + 1;
      if (nv_write) nvw_cnt <= nvw_cnt + 1;
   end
   function automatic logic [1:0] exp_dir(input logic f, input logic r,
      input logic neg);
      if (f == r) return 2'b00;
      return neg ? {r, f} : {f, r};
   endfunction : exp_dir
   function automatic logic [15:0] mag(input logic [15:0] v);
      return v[15] ? -v : v;
   endfunction : mag
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic req(input logic [15:0] v, input logic r, input logic n);
      ram_base = ram_cnt;
      nv_base = nv_cnt;
      nvw_base = nvw_cnt;
      sfc_master_model_inst.request(v, r, n);
   endtask : req
   task automatic code(input logic [7:0] c, input logic [15:0] v);
      @(posedge clock);
      code_valid <= 1'b1;
      code_value <= c;
      code_data <= v;
      @(posedge clock);
      code_valid <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : code
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      close_out();
   end
   initial begin
      void'($urandom(83));
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      rd(SFC_ADDR_CTRL);
      check("ctrl", d, {29'h0, SFC_CTRL_RESET});
      check("freq", set_freq, SFC_FREQ_RESET);
      for (int i = 0; i < 4; i++) begin
         w = (i == 0) ? SFC_FREQ_MAX_UNSCALED : 16'($urandom_range(59000));
         req(w, 1'b1, 1'b0);
         check("unsigned", set_freq, w);
         check("ram done", ram_cnt - ram_base, 1);
      end
      req(SFC_FREQ_MAX_UNSCALED + 16'h1, 1'b1, 1'b0);
      check("range err", error_code, SFC_ERR_RANGE);
      check("kept", set_freq, w);
      rd(SFC_ADDR_FREQ);
      check("freq reg", d, {16'h0, w});
      wr(SFC_ADDR_CTRL, 32'h4);
      req(16'hffff, 1'b1, 1'b0);
      check("scaled", set_freq, 16'hffff);
      req(16'h1000, 1'b0, 1'b1);
      check("nv freq", set_freq, 16'h1000);
      check("nv done", nv_cnt - nv_base, 1);
      check("nv store", nvw_cnt - nvw_base, 1);
      $display("test unsigned done");
      wr(SFC_ADDR_CTRL, 32'h3);
      for (int k = 0; k < 8; k++) begin
         w = (k == 0) ? 16'h8000 : 16'($urandom);
         fwd_cmd <= k[0];
         rev_cmd <= k[1] ^ k[2];
         req(w, 1'b1, 1'b0);
         check("magnitude", set_freq, mag(w));
         check("sign", set_sign_neg, w[15]);
         check("dir", {run_fwd, run_rev},
               exp_dir(fwd_cmd, rev_cmd, w[15]));
      end
      w = set_freq;
      req(16'h0010, 1'b0, 1'b1);
      check("wm err", error_code, SFC_ERR_WRITE_MODE);
      check("no nv", nv_cnt - nv_base, 0);
      check("no store", set_freq, w);
      req(16'hfff0, 1'b1, 1'b1);
      check("both ram", ram_cnt - ram_base, 1);
      check("both nv", nv_cnt - nv_base, 0);
      code(SFC_CODE_WR_RAM, 16'h1234);
      check("code freq", set_freq, 16'h1234);
      check("code sign", set_sign_neg, 1'b1);
      code(SFC_CODE_WR_NV, 16'h0456);
      check("code nv err", error_code, SFC_ERR_WRITE_MODE);
      check("code nv sign", set_sign_neg, 1'b1);
      $display("test signed done");
      wr(SFC_ADDR_IRQ_STAT, 32'h1f);
      wr(SFC_ADDR_IRQ_MASK, 32'h0);
      req(16'h0030, 1'b1, 1'b0);
      check("irq masked", irq, 1'b0);
      wr(SFC_ADDR_IRQ_MASK, 32'h1f);
      repeat (2) @(posedge clock);
      check("irq set", irq, 1'b1);
      wr(SFC_ADDR_IRQ_STAT, 32'h1f);
      wr(SFC_ADDR_IRQ_MASK, 32'h0);
      rd(4'hf);
      check("unmapped", d, 32'h0);
      sfc_master_model_inst.pulse_cmd(1'b0);
      rd(SFC_ADDR_IRQ_STAT);
      check("idle reset", d[SFC_IRQ_FAULT_RESET], 1'b0);
      @(posedge clock);
      fault_code <= 8'($urandom_range(255, 1));
      fault_event <= 1'b1;
      @(posedge clock);
      fault_event <= 1'b0;
      repeat (3) @(posedge clock);
      check("fault", fault_active, 1'b1);
      rd(SFC_ADDR_FAULT_BASE);
      check("record", d, {24'h0, fault_code});
      rd(SFC_ADDR_STATUS);
      check("hist count", d[7:4], 4'h1);
      sfc_master_model_inst.pulse_cmd(1'b0);
      check("fault reset", fault_active, 1'b0);
      sfc_master_model_inst.pulse_cmd(1'b1);
      rd(SFC_ADDR_FAULT_BASE);
      check("hist clear", d, 32'h0);
      rd(SFC_ADDR_STATUS);
      check("count clear", d[7:4], 4'h0);
      $display("test fault done");
      w = set_freq;
      clk_en <= 1'b0;
      code(SFC_CODE_WR_RAM, 16'h0777);
      check("frozen", set_freq, w);
      clk_en <= 1'b1;
      $display("test freeze done");
      refresh_run <= 1'b0;
      repeat (90) @(posedge clock);
      check("timeout", refresh_timeout, 1'b1);
      refresh_run <= 1'b1;
      repeat (60) @(posedge clock);
      check("refresh", refresh_timeout, 1'b0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(SFC_ADDR_CTRL);
      check("reset sign", set_sign_neg, 1'b0);
      check("reset freq", set_freq, SFC_FREQ_RESET);
      check("reset ctrl", d, {29'h0, SFC_CTRL_RESET});
      $display("test reset done");
      close_out();
   end
endmodule : signed_frequency_command_bench
`default_nettype wire
